// ### hdl/sram_port_pkg.sv
// Shared constants and types for the synchronous late-write static RAM port
// Behaviour
// RULE1: Clock-gate input high makes the device ignore that clock edge completely; the code still registers sleep and output enable on it.
// RULE2: All inputs except output enable, burst-order strap and sleep use rising edges; the code registers output enable and sleep on rising edges too.
// RULE3: Controller holds advance/load low to start a new access with a fresh address.
// RULE4: Device selected only when first select low, second high, third low.
// RULE5: Each byte lane is written only when its own low-active enable is asserted.
// RULE6: Write with no lane enabled leaves memory unchanged, a no-operation.
// RULE7: Read starts on an active, selected edge with write high and advance/load low.
// RULE8: Pipelined mode registers read data, driven one edge after the address edge.
// RULE9: Write starts on an active, selected edge with write low; controls registered.
// RULE10: Pipelined mode: controller supplies write data at third edge from command.
// RULE11: Flow-through mode drives read data right after the address edge.
// RULE12: Flow-through mode: controller supplies write data at the second edge.
// RULE13: Read and write latencies match per mode so they alternate back to back.
// RULE14: Advance/load high steps the burst counter and uses its address.
// RULE15: Two low address bits preset the burst counter when an address loads.
// RULE16: Output-register strap low selects flow-through, otherwise pipelined.
// RULE17: Burst-order strap low selects linear order, high selects interleaved.
// RULE18: Sleep input high puts the device to sleep with data outputs off.
// RULE19: Output enable high turns the data drivers off whatever the read state.
// RULE20: Burst counter wraps to its start after four addresses.
// RULE21: Data drivers turn off by themselves during write cycles.
// RULE22: Stall during pipelined read keeps bus driven; during write keeps it off.
// RULE23: Linear adds count modulo four; interleaved XORs loaded bits with count.
package sram_port_pkg;

  // Geometry defaults
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int ADDR_W      = 17;
  localparam int BURST_W     = 2;

  // Burst counter values
  localparam logic [BURST_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] CNT_ONE  = 2'h1;

  // Kind of access that a burst continue repeats
  typedef enum logic [1:0] {
    K_DESEL,
    K_READ,
    K_WRITE
  } kind_e;

endpackage

// ### hdl/mem_port_if.sv
// Port bundle between the access controller and the storage array
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if #(
  parameter int ADDR_W = 17,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
);
  logic                     rd_en;   // Read strobe for this edge
  logic [ADDR_W-1:0]        rd_addr; // Read word address
  logic [LANES*LANE_W-1:0]  rdata;   // Registered read data
  logic                     wr_en;   // Write strobe for this edge
  logic [ADDR_W-1:0]        wr_addr; // Write word address
  logic [LANES-1:0]         wr_be;   // Lane write mask, active high
  logic [LANES*LANE_W-1:0]  wdata;   // Write data

  modport ctrl  (output rd_en, rd_addr, wr_en, wr_addr, wr_be, wdata, input rdata);
  modport array (input rd_en, rd_addr, wr_en, wr_addr, wr_be, wdata, output rdata);
endinterface
`default_nettype wire

// ### hdl/sram_array.sv
// Storage array with lane-masked writes and a registered read port
`timescale 1ns/1ps
`default_nettype none
module sram_array #(
  parameter int ADDR_W = 17,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input  wire logic  i_ref_clk,   // Core clock
  input  wire logic  i_reset_n,   // Async reset, active low
  mem_port_if.array  port         // Controller side
);

  logic [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
  logic [LANES*LANE_W-1:0] next_rdata;
  logic [LANES*LANE_W-1:0] rdata;

  //----------------------------------------------------------------
  // Write port
  //----------------------------------------------------------------
  // Each lane lands only under its own mask bit; one process keeps the array single-driven
  always_ff @(posedge i_ref_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (port.wr_en && port.wr_be[l]) begin // see RULE5
        store[port.wr_addr][l*LANE_W +: LANE_W] <= port.wdata[l*LANE_W +: LANE_W];
      end
    end
  end

  //----------------------------------------------------------------
  // Read port with same-edge write bypass
  //----------------------------------------------------------------
  // Bypass keeps a read coherent with a write landing on the same edge
  always_comb begin
    next_rdata = rdata;
    if (port.rd_en) begin
      next_rdata = store[port.rd_addr];
      for (int l = 0; l < LANES; l++) begin
        if (port.wr_en && port.wr_be[l] && port.wr_addr == port.rd_addr) begin
          next_rdata[l*LANE_W +: LANE_W] = port.wdata[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Read data register, held while no read is issued
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign port.rdata = rdata;

  chk_abort_no_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    port.wr_en |-> (port.wr_be != '0)) else $error("write issued with empty lane mask"); // see RULE6

endmodule
`default_nettype wire

// ### hdl/sync_sram_turnaround_free_port.sv
// Access controller for the late-write synchronous static RAM port
`timescale 1ns/1ps
`default_nettype none
module sync_sram_turnaround_free_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W,
  parameter int LANES  = sram_port_pkg::LANES,
  parameter int LANE_W = sram_port_pkg::LANE_W
) (
  input  wire logic                    i_ref_clk,                // Core clock
  input  wire logic                    i_reset_n,                // Async reset, active low
  input  wire logic                    i_clock_enable_n,         // High stalls the edge
  input  wire logic                    i_advance_load,           // High advance, low load
  input  wire logic                    i_chip_select_first_n,    // Select, active low
  input  wire logic                    i_chip_select_second,     // Select, active high
  input  wire logic                    i_chip_select_third_n,    // Select, active low
  input  wire logic                    i_write_n,                // Write, active low
  input  wire logic [LANES-1:0]        i_lane_write_en_n,        // Lane write enables, active low
  input  wire logic [ADDR_W-1:0]       i_addr,                   // Word address
  input  wire logic [LANES*LANE_W-1:0] i_dq_in,                  // Data pins, input side
  output var  logic [LANES*LANE_W-1:0] o_dq_out,                 // Data pins, output side
  output var  logic                    o_dq_oe_n,                // Low while driving data pins
  input  wire logic                    i_out_enable_n,           // Output enable, active low
  input  wire logic                    i_sleep_request,          // Sleep, active high
  input  wire logic                    i_flowthru_select_n,      // Low selects flow-through
  input  wire logic                    i_linear_order_select_n,  // Low selects linear burst
  output var  logic                    o_sleep_active            // Registered sleep status
);

  localparam int BW = sram_port_pkg::BURST_W;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    sram_port_pkg::kind_e     kind;     // Access a continue repeats
    logic [ADDR_W-1:0]        base;     // Loaded address
    logic [BW-1:0]            start;    // Preset low bits
    logic [BW-1:0]            cnt;      // Burst step count
    logic                     s1_rd;    // Read in first stage
    logic                     s1_wr;    // Write in first stage
    logic [ADDR_W-1:0]        s1_addr;  // First stage address
    logic [LANES-1:0]         s1_be;    // First stage lane mask
    logic                     s2_wr;    // Write in second stage
    logic [ADDR_W-1:0]        s2_addr;  // Second stage address
    logic [LANES-1:0]         s2_be;    // Second stage lane mask
    logic                     drive;    // Read data due on the pins
    logic                     oe_n;     // Pin driver enable, active low
    logic                     sleep;    // Sleep status
  } state_s;

  state_s st;
  state_s next_st;

  mem_port_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) mem_bus ();

  sram_array #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_array (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .port      (mem_bus.array)
  );

  //----------------------------------------------------------------
  // Burst address generation
  //----------------------------------------------------------------
  // Low address bits for a given step of the burst
  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start,
                                              input logic [BW-1:0] cnt,
                                              input logic          linear);
    if (linear) begin
      burst_low = start + cnt;             // see RULE23
    end else begin
      burst_low = start ^ cnt;             // see RULE23
    end
  endfunction

  //----------------------------------------------------------------
  // Command decode
  //----------------------------------------------------------------
  logic                    stall;
  logic                    sel;
  logic                    flow;
  logic                    linear;
  logic                    rd_go;
  logic                    wr_go;
  logic [LANES-1:0]        be;
  logic [BW-1:0]           step;
  logic [ADDR_W-1:0]       acc_addr;

  // Decode pins into this edge's command
  always_comb begin
    stall    = i_clock_enable_n;                                          // see RULE1
    sel      = !i_chip_select_first_n && i_chip_select_second
               && !i_chip_select_third_n;                                 // see RULE4
    flow     = !i_flowthru_select_n;                                      // see RULE16
    linear   = !i_linear_order_select_n;                                  // see RULE17
    be       = ~i_lane_write_en_n;
    step     = st.cnt + sram_port_pkg::CNT_ONE;                           // see RULE20
    acc_addr = i_addr;
    if (i_advance_load) begin
      acc_addr = {st.base[ADDR_W-1:BW], burst_low(st.start, step, linear)}; // see RULE14
    end
    if (i_advance_load) begin
      rd_go = !stall && st.kind == sram_port_pkg::K_READ;
      wr_go = !stall && st.kind == sram_port_pkg::K_WRITE;
    end else begin
      rd_go = !stall && sel && i_write_n;                                 // see RULE7
      wr_go = !stall && sel && !i_write_n;                                // see RULE9
    end
  end

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  // Burst tracking, access pipeline and pin driver control
  always_comb begin
    next_st = st;
    if (!stall) begin                                                     // see RULE1
      // Burst tracking
      if (i_advance_load) begin
        next_st.cnt = step;                                               // see RULE14
      end else begin
        next_st.base  = i_addr;                                           // see RULE3
        next_st.start = i_addr[BW-1:0];                                   // see RULE15
        next_st.cnt   = sram_port_pkg::CNT_ZERO;
        if (!sel) begin
          next_st.kind = sram_port_pkg::K_DESEL;
        end else if (i_write_n) begin
          next_st.kind = sram_port_pkg::K_READ;
        end else begin
          next_st.kind = sram_port_pkg::K_WRITE;
        end
      end
      // First stage takes this edge's access
      next_st.s1_rd   = rd_go;
      next_st.s1_wr   = wr_go && (be != '0);                              // see RULE6
      next_st.s1_addr = acc_addr;
      next_st.s1_be   = be;                                               // see RULE5
      // Second stage delays writes once more for pipelined mode
      next_st.s2_wr   = st.s1_wr;
      next_st.s2_addr = st.s1_addr;
      next_st.s2_be   = st.s1_be;
      // Data due on the pins only after reads, never after writes
      next_st.drive   = flow ? rd_go : st.s1_rd;                          // see RULE8, see RULE11, see RULE21
    end
    // Stalled edges keep drive as it was, so a read stays on the bus
    next_st.oe_n  = !(next_st.drive && !i_out_enable_n && !i_sleep_request); // see RULE18, see RULE19, see RULE22
    next_st.sleep = i_sleep_request;
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st       <= '0;
      st.kind  <= sram_port_pkg::K_DESEL;
      st.oe_n  <= 1'b1;
    end else begin
      st <= next_st;                                                      // see RULE2
    end
  end

  //----------------------------------------------------------------
  // Storage array hookup
  //----------------------------------------------------------------
  // Pipelined reads use the delayed address so the array register acts as output register
  always_comb begin
    mem_bus.rd_en   = !stall && (flow ? rd_go : st.s1_rd);                // see RULE8, see RULE11
    mem_bus.rd_addr = flow ? acc_addr : st.s1_addr;
    mem_bus.wr_en   = !stall && (flow ? st.s1_wr : st.s2_wr);             // see RULE10, see RULE12, see RULE13
    mem_bus.wr_addr = flow ? st.s1_addr : st.s2_addr;
    mem_bus.wr_be   = flow ? st.s1_be : st.s2_be;
    mem_bus.wdata   = i_dq_in;
  end

  // Outputs straight from registers
  assign o_dq_out       = mem_bus.rdata;
  assign o_dq_oe_n      = st.oe_n;
  assign o_sleep_active = st.sleep;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  chk_stall_freezes_state: assert property ( // see RULE1
    stall |=> ($stable(st.cnt) && $stable(st.s1_rd) && $stable(st.s1_wr) && $stable(st.drive)
               && $stable(st.kind)))
    else $error("state changed on a stalled edge");

  chk_deselect_no_read: assert property ( // see RULE4
    (!stall && !i_advance_load && !sel) |=> (!st.s1_rd && !st.s1_wr && st.kind == sram_port_pkg::K_DESEL))
    else $error("deselected edge started an access");

  chk_pipe_read_latency: assert property ( // see RULE8
    (!flow && rd_go) ##1 (!stall && !i_out_enable_n && !i_sleep_request && !flow) |=> !o_dq_oe_n)
    else $error("pipelined read not driven on second edge");

  chk_flow_read_latency: assert property ( // see RULE11
    (flow && rd_go && !i_out_enable_n && !i_sleep_request) |=> !o_dq_oe_n)
    else $error("flow-through read not driven after address edge");

  chk_oe_high_off: assert property ( // see RULE19
    i_out_enable_n |=> o_dq_oe_n)
    else $error("drivers on while output enable high");

  chk_sleep_off: assert property ( // see RULE18
    i_sleep_request |=> (o_dq_oe_n && o_sleep_active))
    else $error("drivers on during sleep");

  chk_write_no_drive: assert property ( // see RULE21
    (flow && wr_go) |=> o_dq_oe_n)
    else $error("drivers on during write cycle");

  chk_pipe_write_edge: assert property ( // see RULE10
    (!flow && wr_go && be != '0) ##1 (!stall && !flow) |-> ##1 (!flow && !stall) |-> mem_bus.wr_en)
    else $error("pipelined write not issued on third edge");

  chk_flow_write_edge: assert property ( // see RULE12
    (flow && wr_go && be != '0) ##1 (flow && !stall) |-> mem_bus.wr_en)
    else $error("flow-through write not issued on second edge");

  chk_burst_step_wrap: assert property ( // see RULE20
    (!stall && i_advance_load) |=> st.cnt == $past(st.cnt) + sram_port_pkg::CNT_ONE)
    else $error("burst counter did not step");

  chk_load_preset: assert property ( // see RULE15
    (!stall && !i_advance_load) |=> (st.start == $past(i_addr[1:0]) && st.cnt == sram_port_pkg::CNT_ZERO))
    else $error("burst counter not preset on load");

  chk_stall_keeps_read: assert property ( // see RULE22
    (st.drive && stall) |=> st.drive)
    else $error("stall dropped a pending read");

  cov_pipe_read:   cover property (!flow && rd_go ##2 !o_dq_oe_n);
  cov_flow_write:  cover property (flow && wr_go ##1 mem_bus.wr_en);
  cov_burst_wrap:  cover property ((!stall && i_advance_load && st.cnt == 2'h3));
  cov_read_write:  cover property (rd_go ##1 wr_go ##1 rd_go);

endmodule
`default_nettype wire

// ### sim/sram_ctl_model.sv
// Controller model: drives commands and late-write data
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_model #(
  parameter int AW = 6
) (
  input  wire logic          i_ref_clk, // Core clock
  input  wire logic          i_reset_n, // Async reset, active low
  input  wire logic          i_flow,    // High in flow-through mode
  output var  logic          o_ce_n,    // High stalls the edge
  output var  logic          o_adv,     // Low loads an address
  output var  logic [2:0]    o_sel,     // Selects, first/second/third
  output var  logic          o_wr_n,    // Write, active low
  output var  logic [3:0]    o_be_n,    // Lane enables, active low
  output var  logic [AW-1:0] o_addr,    // Word address
  output var  logic [35:0]   o_dq       // Data it puts on the bus
);
  logic [35:0] cmd_d = 36'h0;
  logic [35:0] wq_d[$];
  int          wq_n[$];
  logic        in_wr;

  initial begin
    {o_ce_n, o_adv, o_sel, o_wr_n, o_be_n, o_addr, o_dq} = '1;
  end

  // One command, changed just after an edge, taken at the next
  task automatic cmd(input logic st, input logic advance_load, input logic [2:0] sel, input logic wr_n,
                     input logic [3:0] be_n, input logic [AW-1:0] a, input logic [35:0] d);
    @(posedge i_ref_clk);
    o_ce_n <= st;
    o_adv  <= advance_load;
    o_sel  <= sel;
    o_wr_n <= wr_n;
    o_be_n <= be_n;
    o_addr <= a;
    cmd_d  <= d;
  endtask

  // Data goes out one edge before the edge that samples it; idle bus toggles
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wq_d.delete();
      wq_n.delete();
      in_wr = 1'b0;
    end else if (!o_ce_n) begin
      foreach (wq_n[x]) wq_n[x]--;
      if (wq_n.size() > 0 && wq_n[0] == 0) begin
        void'(wq_n.pop_front());
        void'(wq_d.pop_front());
      end
      if (!o_adv) in_wr = (o_sel == 3'h2) && !o_wr_n;
      if (in_wr) begin
        wq_d.push_back(cmd_d);
        wq_n.push_back(i_flow ? 1 : 2);
      end
      o_dq <= (wq_n.size() > 0 && wq_n[0] == 1) ? wq_d[0] : ~o_dq;
    end else if (wq_n.size() == 0 || wq_n[0] != 1) begin
      o_dq <= ~o_dq;
    end
  end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the synchronous static RAM port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        oe_n = 1'b0;
  logic        sleep = 1'b0;
  logic        flow_n = 1'b1;
  logic        lin_n = 1'b0;
  logic        ce_n, advance_load, wr_n;
  logic [2:0]  sel;
  logic [3:0]  be_n;
  logic [5:0]  addr, a, base, p1_a;
  logic [1:0]  cnt;
  logic [35:0] ctl_dq, dq_bus, dq_out, show_d;
  logic        dq_oe_n, sleep_act, show_v, p1_v, oe_q, sl_q;
  logic [35:0] mem [0:63];
  logic [5:0]  pa[$];
  logic [3:0]  pb[$];
  int          pn[$];
  int          k, l, cycles, errors, tests_run;

  always #10 ref_clk = ~ref_clk;
  assign dq_bus = !dq_oe_n ? dq_out : ctl_dq;

  sync_sram_turnaround_free_port #(.ADDR_W(6)) dut (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_clock_enable_n(ce_n), .i_advance_load(advance_load),
    .i_chip_select_first_n(sel[2]), .i_chip_select_second(sel[1]), .i_chip_select_third_n(sel[0]),
    .i_write_n(wr_n), .i_lane_write_en_n(be_n), .i_addr(addr), .i_dq_in(dq_bus),
    .i_out_enable_n(oe_n), .i_sleep_request(sleep), .i_flowthru_select_n(flow_n),
    .i_linear_order_select_n(lin_n), .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .o_sleep_active(sleep_act)
  );

  sram_ctl_model #(.AW(6)) ctl (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_flow(!flow_n), .o_ce_n(ce_n), .o_adv(advance_load),
    .o_sel(sel), .o_wr_n(wr_n), .o_be_n(be_n), .o_addr(addr), .o_dq(ctl_dq)
  );

  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic give_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Reference model: checks the outputs left by the last edge, then steps
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {k, show_v, p1_v, oe_q, sl_q} = '0;
      pa.delete();
      pb.delete();
      pn.delete();
    end else begin
      tests_run += 3;
      if (dq_oe_n !== !(show_v && !oe_q && !sl_q)) fail("driver enable");
      if (show_v && !oe_q && !sl_q && dq_out !== show_d) fail("read data");
      if (sleep_act !== sl_q) fail("sleep status");
      oe_q = oe_n;
      sl_q = sleep;
      if (!ce_n) begin
        foreach (pn[x]) pn[x]--;
        if (pn.size() > 0 && pn[0] == 0) begin
          for (l = 0; l < 4; l++) if (!pb[0][l]) mem[pa[0]][9*l+:9] = dq_bus[9*l+:9];
          void'(pn.pop_front());
          void'(pa.pop_front());
          void'(pb.pop_front());
        end
        // Pipelined data is looked up on the delivering edge, after that edge's write
        show_v = p1_v;
        show_d = mem[p1_a];
        p1_v = 1'b0;
        if (!advance_load) begin
          base = addr;
          cnt = 2'h0;
          k = (sel == 3'h2) ? (wr_n ? 1 : 2) : 0;
        end else cnt++;
        a = {base[5:2], lin_n ? base[1:0] ^ cnt : base[1:0] + cnt};
        if (k == 2) begin
          pa.push_back(a);
          pb.push_back(be_n);
          pn.push_back(flow_n ? 2 : 1);
        end
        if (k == 1) begin
          p1_v = 1'b1;
          p1_a = a;
        end
        if (!flow_n) begin
          show_v = p1_v;
          show_d = mem[p1_a];
          p1_v = 1'b0;
        end
      end
    end
  end

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      give_verdict();
    end
  end

  initial begin
    int          i, j;
    logic [31:0] r;
    logic [2:0]  s;
    void'($urandom(32'h57FA));
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        reset_n <= 1'b0;
        flow_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
      end
      // Fill every word with four-beat write bursts
      for (i = 0; i < 64; i++) ctl.cmd(0, i % 4 != 0, 3'h2, 0, 4'h0, (i % 4 != 0) ? 6'($urandom) : 6'(i),
                                       36'({$urandom(), $urandom()}));
      // Read bursts in both orders, the last one deselected
      for (i = 0; i < 8; i++) begin
        lin_n <= i[0];
        for (j = 0; j < 4; j++) ctl.cmd(0, j != 0, (i == 7) ? 3'h0 : 3'h2, 1, 4'(j), 6'($urandom), 36'h0);
      end
      // Writes and reads back to back, with stalls, aborts, OE and sleep
      for (i = 0; i < 60; i++) begin
        r = $urandom;
        oe_n <= r[4:2] == 3'h0;
        sleep <= r[7:5] == 3'h0;
        s = (r[10:8] == 3'h0) ? r[13:11] : 3'h2;
        if (r[1:0] == 2'h0) ctl.cmd(1, r[14], r[17:15], r[18], r[22:19], r[28:23], 36'h0);
        ctl.cmd(0, 0, s, 0, (i < 4) ? ~(4'h1 << i) : r[22:19], 6'((i * 5) % 64),
                36'({$urandom(), $urandom()}));
        ctl.cmd(0, 0, 3'h2, 1, r[26:23], 6'((i * 5 + 49) % 64), 36'h0);
      end
      oe_n <= 1'b0;
      sleep <= 1'b0;
      repeat (4) ctl.cmd(0, 0, 3'h7, 1, 4'hF, 6'h0, 36'h0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
